// [mmh_map.svh]
// register map, field positions, reset values and timing counts of the message handler
`ifndef MMH_MAP_SVH
`define MMH_MAP_SVH
// *********************************************************
// register offsets (byte addresses)
// *********************************************************
`define MMH_OFS_CTRL 5'h00
`define MMH_OFS_TEMPO 5'h04
`define MMH_OFS_EVENT 5'h08
`define MMH_OFS_LEVELS 5'h0C
`define MMH_OFS_STATUS 5'h10
// *********************************************************
// field positions
// *********************************************************
`define MMH_CTRL_MAIN 3:0
`define MMH_CTRL_PLAY 7:4
`define MMH_CTRL_SAMPLING 8
`define MMH_CTRL_LOCAL 9
`define MMH_CTRL_TSRC 11:10
`define MMH_CTRL_ROUTE 13:12
`define MMH_CTRL_KNOB1_ASG 14
`define MMH_CTRL_KNOB2_ASG 15
`define MMH_EVT_KIND 1:0
`define MMH_EVT_DATA 14:8
`define MMH_EVT_VEL 22:16
// *********************************************************
// reset values
// *********************************************************
`define MMH_CTRL_RST 16'h0200
`define MMH_TEMPO_RST 32'h001FCA05
`define MMH_VOL_DEF 7'h64
`define MMH_PAN_DEF 7'h40
`define MMH_BEND_CENTRE 14'h0000
// *********************************************************
// message codes
// *********************************************************
`define MMH_ST_NOTE_OFF 4'h8
`define MMH_ST_NOTE_ON 4'h9
`define MMH_ST_CC 4'hB
`define MMH_ST_PROG 4'hC
`define MMH_ST_PRESS 4'hD
`define MMH_ST_BEND 4'hE
`define MMH_TIMING_CLOCK 8'hF8
`define MMH_REALTIME_MIN 8'hF8
`define MMH_SYSTEM_MIN 8'hF0
`define MMH_CC_KNOB1 7'h0C
`define MMH_CC_KNOB2 7'h0D
`define MMH_CC_VOLUME 7'h07
`define MMH_CC_PAN 7'h0A
`define MMH_CC_ALL_NOTES_OFF 7'h7B
`define MMH_CC_ALL_SOUND_OFF 7'h78
`define MMH_CC_RESET_CTRL 7'h79
`define MMH_OFF_VELOCITY 7'h40
`define MMH_RESP_OKAY 2'h0
`define MMH_RESP_SLVERR 2'h2
// *********************************************************
// timing
// *********************************************************
`define MMH_CLK_NS 10
`define MMH_BIT_NS 32000
`define MMH_BIT_CYC (`MMH_BIT_NS / `MMH_CLK_NS)
`define MMH_HALF_BIT_CYC (`MMH_BIT_CYC / 2)
`define MMH_EXT_TIMEOUT_MS 300
`endif

// [mmh_pkg.sv]
// types shared by the message handler files
package mmh_pkg;
  typedef enum logic [1:0] {MMH_TS_INT, MMH_TS_EXT, MMH_TS_AUTO, MMH_TS_RSV} mmh_tsrc_e;
  typedef enum logic [1:0] {MMH_RT_BOTH, MMH_RT_USB, MMH_RT_SERIAL, MMH_RT_RSV} mmh_route_e;
  typedef struct packed {
    logic [7:0] run;
    logic haveD1;
    logic [6:0] d1;
    logic msgValid;
    logic [7:0] msgStat;
    logic [6:0] msgD1;
    logic [6:0] msgD2;
    logic clkTick;
  } mmh_prs_s;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [31:0] tempoPer;
    logic [6:0] vol;
    logic [6:0] pan;
    logic [6:0] fx1;
    logic [6:0] fx2;
    logic [13:0] bend;
    logic awHave;
    logic [4:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic rx1;
    logic rx2;
    logic rxBusy;
    logic [11:0] rxCnt;
    logic [3:0] rxBit;
    logic [7:0] rxSh;
    logic [7:0] rxByte;
    logic rxStb;
    logic [9:0] txSh;
    logic [3:0] txLeft;
    logic [11:0] txCnt;
    logic [23:0] txMsg;
    logic [1:0] txLen;
    logic clkPend;
    logic [31:0] tempoCnt;
    logic [31:0] extCnt;
    logic extActive;
    logic tick;
    logic sgStb;
    logic sgOn;
    logic [6:0] sgKey;
    logic [6:0] sgVel;
    logic allNotesOff;
    logic allSoundOff;
    logic [7:0] usbTxByte;
    logic usbTxValid;
  } mmh_st_s;
endpackage : mmh_pkg

// [mmh_msg_parser.sv]
// byte stream to channel message parser with running status
`timescale 1ns/100ps
`default_nettype none
`include "mmh_map.svh"
module mmh_msg_parser
  import mmh_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] byteIn,
  input wire logic byteValid,
  output logic msgValid,
  output logic [7:0] msgStat,
  output logic [6:0] msgD1,
  output logic [6:0] msgD2,
  output logic clkTick
);
  mmh_prs_s s, n;
  logic twoData;

  assign twoData = (s.run[7:4] != `MMH_ST_PROG) && (s.run[7:4] != `MMH_ST_PRESS);

  always_comb
  begin
    n = s;
    n.msgValid = 1'b0;
    n.clkTick = 1'b0;
    if (byteValid)
    begin
      // realtime bytes may sit inside a message and leave it intact
      if (byteIn >= `MMH_REALTIME_MIN)
      begin
        n.clkTick = (byteIn == `MMH_TIMING_CLOCK);
      end
      else if (byteIn[7])
      begin
        n.run = (byteIn < `MMH_SYSTEM_MIN) ? byteIn : 8'h00;
        n.haveD1 = 1'b0;
      end
      else if (s.run != 8'h00)
      begin
        if (twoData && !s.haveD1)
        begin
          n.d1 = byteIn[6:0];
          n.haveD1 = 1'b1;
        end
        else
        begin
          n.msgValid = 1'b1;
          n.msgStat = s.run;
          n.msgD1 = twoData ? s.d1 : byteIn[6:0];
          n.msgD2 = twoData ? byteIn[6:0] : 7'h00;
          n.haveD1 = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= n;
  end

  assign msgValid = s.msgValid;
  assign msgStat = s.msgStat;
  assign msgD1 = s.msgD1;
  assign msgD2 = s.msgD2;
  assign clkTick = s.clkTick;

  chk_clock_passes: assert property (@(posedge clk) disable iff (!rst_n)
    (byteValid && byteIn == `MMH_TIMING_CLOCK) |=> clkTick && !msgValid)
    else $error("timing clock byte not passed on");
  chk_running_status: assert property (@(posedge clk) disable iff (!rst_n)
    msgValid && msgStat[7:4] == `MMH_ST_CC && !byteValid ##1 (byteValid && !byteIn[7]) ##1 !byteValid
    ##1 (byteValid && !byteIn[7]) |=> msgValid && msgStat == $past(msgStat, 4))
    else $error("running status message lost");
endmodule : mmh_msg_parser
`default_nettype wire

// [mmh_message_handler.sv]
// channel message handler: register slave, serial link, filters and tempo source
//
// How it works
// - sixteen channels; accept only matching channel
// - sampling state uses main channel only
// - key press/release emits 9n/8n messages
// - send release velocity 64; ignore received
// - bend only keyboard state, play channel
// - bend bytes form signed value, 64/0 centre
// - knobs emit CC12 and CC13 on main
// - assigned knob CC updates effect parameter
// - volume CC7 only keyboard state, play channel
// - pan CC10 only keyboard state, play channel
// - CC123 value 0 ends sounding notes
// - CC120 value 0 silences channel at once
// - CC121 value 0 resets controller defaults
// - internal source: send timing clock from tempo
// - external source: follow received timing clock; usb clock only with usb-only route
// - automatic: external while clocks arrive, else internal
// - local off: keys skip own sound generator
// - notes received on play channel, keyboard state
// - merge both inputs; send on both outputs; on a same-cycle tie with a usb message the serial message is dropped
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "mmh_map.svh"
module mmh_message_handler
  import mmh_pkg::*;
#(
  parameter int EXT_TIMEOUT_CYC = `MMH_EXT_TIMEOUT_MS * (1000000 / `MMH_CLK_NS)
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serialRx,
  output logic serialTx,
  input wire logic [7:0] usbRxByte,
  input wire logic usbRxValid,
  output logic [7:0] usbTxByte,
  output logic usbTxValid,
  output logic tempoTick,
  output logic sgNoteStb,
  output logic sgNoteOn,
  output logic [6:0] sgNoteKey,
  output logic [6:0] sgNoteVel,
  output logic allNotesOff,
  output logic allSoundOff,
  output logic [6:0] volumeLevel,
  output logic [6:0] panPosition,
  output logic [6:0] fxParam1,
  output logic [6:0] fxParam2,
  output logic [13:0] bendValue
);
  // *********************************************************
  // elaboration check
  // *********************************************************
  if (EXT_TIMEOUT_CYC < 2)
  begin : g_bad_timeout
    $error("EXT_TIMEOUT_CYC must be at least 2");
  end

  mmh_st_s s, n;
  mmh_tsrc_e tsrc;
  mmh_route_e route;
  logic useSerial, useUsb, sampling, useInt, extTick, intTick;
  logic pSValid, pSClk, pUValid, pUClk;
  logic [7:0] pSStat, pUStat, selStat;
  logic [6:0] pSD1, pSD2, pUD1, pUD2, selD1, selD2;
  logic selValid, onMain, onPlay, noteChan;
  logic [3:0] mainCh, playCh, selCh;
  logic evtWrite;

  assign tsrc = mmh_tsrc_e'(s.ctrl[`MMH_CTRL_TSRC]);
  assign route = mmh_route_e'(s.ctrl[`MMH_CTRL_ROUTE]);
  assign useSerial = (route == MMH_RT_BOTH) || (route == MMH_RT_SERIAL);
  assign useUsb = (route == MMH_RT_BOTH) || (route == MMH_RT_USB);
  assign sampling = s.ctrl[`MMH_CTRL_SAMPLING];
  assign mainCh = s.ctrl[`MMH_CTRL_MAIN];
  assign playCh = s.ctrl[`MMH_CTRL_PLAY];

  // *********************************************************
  // message parsers, one per input
  // *********************************************************
  mmh_msg_parser u_prs_serial (
    .clk(clk),
    .rst_n(rst_n),
    .byteIn(s.rxByte),
    .byteValid(s.rxStb && useSerial),
    .msgValid(pSValid),
    .msgStat(pSStat),
    .msgD1(pSD1),
    .msgD2(pSD2),
    .clkTick(pSClk)
  );
  mmh_msg_parser u_prs_usb (
    .clk(clk),
    .rst_n(rst_n),
    .byteIn(usbRxByte),
    .byteValid(usbRxValid && useUsb),
    .msgValid(pUValid),
    .msgStat(pUStat),
    .msgD1(pUD1),
    .msgD2(pUD2),
    .clkTick(pUClk)
  );

  // a tie between inputs goes to usb; the serial message of that cycle is dropped
  assign selValid = pSValid || pUValid;
  assign selStat = pUValid ? pUStat : pSStat;
  assign selD1 = pUValid ? pUD1 : pSD1;
  assign selD2 = pUValid ? pUD2 : pSD2;
  assign selCh = selStat[3:0];
  assign onMain = (selCh == mainCh);
  assign onPlay = !sampling && (selCh == playCh);
  assign noteChan = sampling ? onMain : onPlay;
  assign extTick = pSClk || (pUClk && route == MMH_RT_USB);
  assign useInt = (tsrc == MMH_TS_INT) || (tsrc == MMH_TS_AUTO && !s.extActive);
  assign intTick = useInt && (s.tempoCnt >= s.tempoPer - 32'h1);
  assign evtWrite = s.awHave && s.wHave && (s.awAddr == `MMH_OFS_EVENT);

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    return r;
  endfunction : mergeStrb

  // *********************************************************
  // next state
  // *********************************************************
  always_comb
  begin
    logic [31:0] wv;
    logic [3:0] txCh;
    logic [7:0] txByte;
    logic txLoad;
    wv = mergeStrb(32'h0, s.wData, s.wStrb);
    txCh = sampling ? mainCh : playCh;
    txByte = 8'h00;
    txLoad = 1'b0;
    n = s;
    n.rxStb = 1'b0;
    n.sgStb = 1'b0;
    n.allNotesOff = 1'b0;
    n.allSoundOff = 1'b0;
    n.usbTxValid = 1'b0;
    n.tick = 1'b0;
    // register bus, write side; address and data may come in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.awHave = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.wHave = 1'b1;
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
    end
    if (s.awHave && s.wHave)
    begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bValid = 1'b1;
      n.bResp = `MMH_RESP_OKAY;
      case (s.awAddr)
        `MMH_OFS_CTRL: n.ctrl = 16'(mergeStrb({16'h0, s.ctrl}, s.wData, s.wStrb));
        `MMH_OFS_TEMPO: n.tempoPer = mergeStrb(s.tempoPer, s.wData, s.wStrb);
        `MMH_OFS_EVENT:
        begin
          // no queue: an event while a message is pending is refused
          if (s.txLen != 2'd0)
            n.bResp = `MMH_RESP_SLVERR;
          else
          begin
            n.txLen = 2'd3;
            case (wv[`MMH_EVT_KIND])
              2'd0: n.txMsg = {`MMH_ST_NOTE_ON, txCh, 1'b0, wv[`MMH_EVT_DATA], 1'b0, wv[`MMH_EVT_VEL]};
              2'd1: n.txMsg = {`MMH_ST_NOTE_OFF, txCh, 1'b0, wv[`MMH_EVT_DATA], 1'b0, `MMH_OFF_VELOCITY};
              2'd2: n.txMsg = {`MMH_ST_CC, mainCh, 1'b0, `MMH_CC_KNOB1, 1'b0, wv[`MMH_EVT_DATA]};
              default: n.txMsg = {`MMH_ST_CC, mainCh, 1'b0, `MMH_CC_KNOB2, 1'b0, wv[`MMH_EVT_DATA]};
            endcase
            if (s.ctrl[`MMH_CTRL_LOCAL] && !wv[1])
            begin
              n.sgStb = 1'b1;
              n.sgOn = !wv[0];
              n.sgKey = wv[`MMH_EVT_DATA];
              if (!wv[0])
                n.sgVel = wv[`MMH_EVT_VEL];
            end
          end
        end
        `MMH_OFS_LEVELS, `MMH_OFS_STATUS: n.bResp = `MMH_RESP_OKAY;
        default: n.bResp = `MMH_RESP_SLVERR;
      endcase
    end
    if (s.bValid && s_axi_bready)
      n.bValid = 1'b0;
    // register bus, read side
    if (s_axi_arvalid && s_axi_arready)
    begin
      n.rValid = 1'b1;
      n.rResp = `MMH_RESP_OKAY;
      case (s_axi_araddr)
        `MMH_OFS_CTRL: n.rData = {16'h0, s.ctrl};
        `MMH_OFS_TEMPO: n.rData = s.tempoPer;
        `MMH_OFS_EVENT: n.rData = 32'h0;
        `MMH_OFS_LEVELS: n.rData = {1'b0, s.fx2, 1'b0, s.fx1, 1'b0, s.pan, 1'b0, s.vol};
        `MMH_OFS_STATUS: n.rData = {14'h0, (s.txLen != 2'd0) || (s.txLeft != 4'd0), s.extActive, 2'b0, s.bend};
        default:
        begin
          n.rData = 32'h0;
          n.rResp = `MMH_RESP_SLVERR;
        end
      endcase
    end
    if (s.rValid && s_axi_rready)
      n.rValid = 1'b0;
    // serial receiver; only the second sync stage is looked at
    n.rx1 = serialRx;
    n.rx2 = s.rx1;
    if (!s.rxBusy)
    begin
      if (!s.rx2)
      begin
        n.rxBusy = 1'b1;
        n.rxCnt = 12'(`MMH_HALF_BIT_CYC);
        n.rxBit = 4'd0;
      end
    end
    else if (s.rxCnt != 12'd0)
      n.rxCnt = s.rxCnt - 12'd1;
    else
    begin
      n.rxCnt = 12'(`MMH_BIT_CYC - 1);
      if (s.rxBit == 4'd0)
      begin
        n.rxBusy = !s.rx2;
        n.rxBit = 4'd1;
      end
      else if (s.rxBit < 4'd9)
      begin
        n.rxSh = {s.rx2, s.rxSh[7:1]};
        n.rxBit = s.rxBit + 4'd1;
      end
      else
      begin
        // a low stop bit is a framing error and the byte is dropped
        n.rxBusy = 1'b0;
        n.rxStb = s.rx2;
        n.rxByte = s.rxSh;
      end
    end
    // received channel messages
    if (selValid)
    begin
      case (selStat[7:4])
        `MMH_ST_NOTE_ON, `MMH_ST_NOTE_OFF:
          if (noteChan)
          begin
            n.sgStb = 1'b1;
            n.sgOn = (selStat[7:4] == `MMH_ST_NOTE_ON) && (selD2 != 7'h00);
            n.sgKey = selD1;
            if (selStat[7:4] == `MMH_ST_NOTE_ON)
              n.sgVel = selD2;
          end
        `MMH_ST_BEND:
          if (onPlay)
            n.bend = {~selD2[6], selD2[5:0], selD1};
        `MMH_ST_CC:
        begin
          if (onMain && selD1 == `MMH_CC_KNOB1 && s.ctrl[`MMH_CTRL_KNOB1_ASG])
            n.fx1 = selD2;
          if (onMain && selD1 == `MMH_CC_KNOB2 && s.ctrl[`MMH_CTRL_KNOB2_ASG])
            n.fx2 = selD2;
          if (onPlay && selD1 == `MMH_CC_VOLUME)
            n.vol = selD2;
          if (onPlay && selD1 == `MMH_CC_PAN)
            n.pan = selD2;
          if ((onMain || onPlay) && selD2 == 7'h00)
          begin
            n.allNotesOff = (selD1 == `MMH_CC_ALL_NOTES_OFF);
            n.allSoundOff = (selD1 == `MMH_CC_ALL_SOUND_OFF);
            if (selD1 == `MMH_CC_RESET_CTRL)
            begin
              n.vol = `MMH_VOL_DEF;
              n.pan = `MMH_PAN_DEF;
              n.bend = `MMH_BEND_CENTRE;
            end
          end
        end
        default: n.sgStb = n.sgStb;
      endcase
    end
    // tempo source
    if (extTick)
    begin
      n.extCnt = 32'h0;
      n.extActive = 1'b1;
    end
    else if (s.extActive)
    begin
      n.extCnt = s.extCnt + 32'h1;
      if (s.extCnt >= 32'(EXT_TIMEOUT_CYC - 1))
        n.extActive = 1'b0;
    end
    if (useInt)
    begin
      n.tempoCnt = intTick ? 32'h0 : s.tempoCnt + 32'h1;
      n.tick = intTick;
      if (intTick)
        n.clkPend = 1'b1;
    end
    else
    begin
      n.tempoCnt = 32'h0;
      n.tick = extTick;
    end
    // serial transmitter, same bytes to both outputs
    if (s.txLeft == 4'd0)
    begin
      if (s.clkPend)
      begin
        txLoad = 1'b1;
        txByte = `MMH_TIMING_CLOCK;
        n.clkPend = intTick;
      end
      else if (s.txLen != 2'd0)
      begin
        txLoad = 1'b1;
        txByte = s.txMsg[23:16];
        n.txMsg = {s.txMsg[15:0], 8'h00};
        n.txLen = s.txLen - 2'd1;
      end
    end
    else if (s.txCnt != 12'd0)
      n.txCnt = s.txCnt - 12'd1;
    else
    begin
      n.txSh = {1'b1, s.txSh[9:1]};
      n.txLeft = s.txLeft - 4'd1;
      n.txCnt = 12'(`MMH_BIT_CYC - 1);
    end
    if (txLoad)
    begin
      n.txSh = {1'b1, txByte, 1'b0};
      n.txLeft = 4'd10;
      n.txCnt = 12'(`MMH_BIT_CYC - 1);
      n.usbTxValid = useUsb;
      n.usbTxByte = txByte;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.ctrl <= `MMH_CTRL_RST;
      s.tempoPer <= `MMH_TEMPO_RST;
      s.vol <= `MMH_VOL_DEF;
      s.pan <= `MMH_PAN_DEF;
      s.rx1 <= 1'b1;
      s.rx2 <= 1'b1;
      s.txSh <= 10'h3FF;
    end
    else
      s <= n;
  end

  // *********************************************************
  // outputs
  // *********************************************************
  assign s_axi_awready = !s.awHave && !s.bValid;
  assign s_axi_wready = !s.wHave && !s.bValid;
  assign s_axi_bvalid = s.bValid;
  assign s_axi_bresp = s.bResp;
  assign s_axi_arready = !s.rValid;
  assign s_axi_rvalid = s.rValid;
  assign s_axi_rdata = s.rData;
  assign s_axi_rresp = s.rResp;
  assign serialTx = useSerial ? s.txSh[0] : 1'b1;
  assign usbTxByte = s.usbTxByte;
  assign usbTxValid = s.usbTxValid;
  assign tempoTick = s.tick;
  assign sgNoteStb = s.sgStb;
  assign sgNoteOn = s.sgOn;
  assign sgNoteKey = s.sgKey;
  assign sgNoteVel = s.sgVel;
  assign allNotesOff = s.allNotesOff;
  assign allSoundOff = s.allSoundOff;
  assign volumeLevel = s.vol;
  assign panPosition = s.pan;
  assign fxParam1 = s.fx1;
  assign fxParam2 = s.fx2;
  assign bendValue = s.bend;

  // *********************************************************
  // checks
  // *********************************************************
  chk_unmatched_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (selValid && !onMain && !onPlay && !evtWrite)
    |=> $stable(volumeLevel) && $stable(panPosition) && $stable(bendValue) && !sgNoteStb)
    else $error("unmatched channel message changed state");
  chk_noteoff_velocity: assert property (@(posedge clk) disable iff (!rst_n)
    (selValid && selStat[7:4] == `MMH_ST_NOTE_OFF && !evtWrite) |=> $stable(sgNoteVel))
    else $error("received note-off velocity was taken");
  chk_bend_value: assert property (@(posedge clk) disable iff (!rst_n)
    (selValid && selStat[7:4] == `MMH_ST_BEND && onPlay)
    |=> bendValue == {~$past(selD2[6]), $past(selD2[5:0]), $past(selD1)})
    else $error("bend value wrong");
  chk_both_outputs: assert property (@(posedge clk) disable iff (!rst_n)
    (usbTxValid && route == MMH_RT_BOTH) |-> !serialTx ##1 !serialTx)
    else $error("usb byte without serial start bit");
  chk_int_clock: assert property (@(posedge clk) disable iff (!rst_n)
    (intTick && !s.clkPend) |=> s.clkPend ##1 (usbTxValid || !useUsb || $past(s.txLeft) != 4'd0))
    else $error("internal tempo did not queue timing clock");
  chk_ext_follow: assert property (@(posedge clk) disable iff (!rst_n)
    (extTick && tsrc == MMH_TS_EXT) |=> tempoTick && s.tempoCnt == 32'h0)
    else $error("external clock not followed");
  chk_all_notes_off: assert property (@(posedge clk) disable iff (!rst_n)
    (selValid && selStat[7:4] == `MMH_ST_CC && selD1 == `MMH_CC_ALL_NOTES_OFF && selD2 == 7'h00
     && (onMain || onPlay)) |=> allNotesOff && !allSoundOff)
    else $error("all notes off not raised");
  chk_local_off: assert property (@(posedge clk) disable iff (!rst_n)
    (evtWrite && !s.ctrl[`MMH_CTRL_LOCAL] && !selValid) |=> !sgNoteStb)
    else $error("local key reached sound generator");
endmodule : mmh_message_handler
`default_nettype wire

// [mmh_far_end.sv]
// far-end device model: usb byte source and sink
`timescale 1ns/100ps
`default_nettype none
module mmh_far_end (
  input wire logic clk,
  output logic serialRx,
  output logic [7:0] usbRxByte,
  output logic usbRxValid,
  input wire logic [7:0] usbTxByte,
  input wire logic usbTxValid
);
  logic [7:0] got[$];
  // serial line idles high; no frames are sent on it
  initial
  begin
    serialRx = 1'b1;
    usbRxByte = 8'h00;
    usbRxValid = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    usbRxByte <= b;
    usbRxValid <= 1'b1;
    @(posedge clk);
    usbRxValid <= 1'b0;
    // released byte shows its inverse, never a stale copy
    usbRxByte <= ~b;
  endtask : send
  always @(posedge clk)
    if (usbTxValid === 1'b1)
      got.push_back(usbTxByte);
endmodule : mmh_far_end
`default_nettype wire

// [test_midi_message_handler.sv]
// testbench of the message handler
`timescale 1ns/100ps
`default_nettype none
`include "mmh_map.svh"
module test_midi_message_handler;
  // ****
  // bench
  // ****
  logic clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic serialRx, serialTx, usbRxValid, usbTxValid, tempoTick, sgNoteStb, sgNoteOn, allNotesOff, allSoundOff;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] usbRxByte, usbTxByte;
  logic [6:0] sgNoteKey, sgNoteVel, volumeLevel, panPosition, fxParam1, fxParam2, lastKey, lastVel;
  logic [13:0] bendValue;
  logic lastOn;
  int fails = 0, n_compared = 0, nStb = 0, nOff = 0, nSnd = 0, nTick = 0, k;
  always #5 clk = ~clk;
  mmh_message_handler #(.EXT_TIMEOUT_CYC(200)) u_mmh_message_handler (.clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serialRx, .serialTx, .usbRxByte,
    .usbRxValid, .usbTxByte, .usbTxValid, .tempoTick, .sgNoteStb, .sgNoteOn, .sgNoteKey, .sgNoteVel,
    .allNotesOff, .allSoundOff, .volumeLevel, .panPosition, .fxParam1, .fxParam2, .bendValue);
  mmh_far_end u_mmh_far_end (.clk, .serialRx, .usbRxByte, .usbRxValid, .usbTxByte, .usbTxValid);
  always @(posedge clk)
  begin
    if (sgNoteStb === 1'b1)
    begin
      nStb++;
      lastOn = sgNoteOn;
      lastKey = sgNoteKey;
      lastVel = sgNoteVel;
    end
    nOff += (allNotesOff === 1'b1);
    nSnd += (allSoundOff === 1'b1);
    nTick += (tempoTick === 1'b1);
  end
  task check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wrap_up;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // a bound that runs out counts as a failure
  task stall;
    fails++;
    wrap_up;
  endtask : stall
  task axw(input logic [4:0] a, input logic [31:0] v);
    int i;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++)
    begin
      @(posedge clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 0;
    end
    if (i == 50)
      stall;
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : axw
  task axr(input logic [4:0] a);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++)
    begin
      @(posedge clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 0;
    end
    if (i == 50)
      stall;
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : axr
  // effect lands two cycles after the last byte
  task msg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    u_mmh_far_end.send(a);
    u_mmh_far_end.send(b);
    u_mmh_far_end.send(c);
    repeat (4) @(posedge clk);
  endtask : msg
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    axr(`MMH_OFS_CTRL);
    check(d, 32'h00000200);
    axr(`MMH_OFS_LEVELS);
    check(d, 32'h00004064);
    axr(5'h14);
    check(r, `MMH_RESP_SLVERR);
    axw(5'h14, 32'hFFFFFFFF);
    check(r, `MMH_RESP_SLVERR);
    msg(8'h90, 8'h3C, 8'h40);
    check({nStb, lastOn, lastKey, lastVel}, {32'd1, 1'b1, 7'h3C, 7'h40});
    msg(8'h80, 8'h3C, 8'h11);
    check({lastOn, lastKey}, {1'b0, 7'h3C});
    msg(8'hB1, 8'h07, 8'h10);
    check(volumeLevel, 7'h64);
    u_mmh_far_end.send(8'hB0);
    u_mmh_far_end.send(8'h07);
    u_mmh_far_end.send(8'h10);
    // running status: pan rides on the volume status, a timing clock trails it
    msg(8'h0A, 8'h22, `MMH_TIMING_CLOCK);
    check({volumeLevel, panPosition}, {7'h10, 7'h22});
    msg(8'hE0, 8'h00, 8'h40);
    check(bendValue, 14'h0000);
    msg(8'hE0, 8'h00, 8'h00);
    check(bendValue, 14'h2000);
    msg(8'hE0, 8'h7F, 8'h7F);
    check(bendValue, 14'h1FFF);
    msg(8'hB0, 8'h79, 8'h00);
    check({volumeLevel, panPosition}, {7'h64, 7'h40});
    msg(8'hB0, 8'h7B, 8'h05);
    msg(8'hB0, 8'h7B, 8'h00);
    msg(8'hB0, 8'h78, 8'h00);
    check({nOff, nSnd}, {32'd1, 32'd1});
    axw(`MMH_OFS_CTRL, 32'h00004301);
    msg(8'hE1, 8'h00, 8'h00);
    check(bendValue, 14'h0000);
    msg(8'hB0, 8'h07, 8'h33);
    msg(8'hB1, 8'h07, 8'h33);
    check(volumeLevel, 7'h64);
    msg(8'h90, 8'h3C, 8'h40);
    msg(8'h91, 8'h3D, 8'h40);
    check({nStb, lastKey}, {32'd3, 7'h3D});
    msg(8'hB1, 8'h0C, 8'h55);
    msg(8'hB1, 8'h0D, 8'h66);
    check({fxParam1, fxParam2}, {7'h55, 7'h00});
    axw(`MMH_OFS_EVENT, 32'h00005502);
    check(r, `MMH_RESP_OKAY);
    axw(`MMH_OFS_EVENT, 32'h00005502);
    check(r, `MMH_RESP_SLVERR);
    for (k = 0; k < 70000 && u_mmh_far_end.got.size() < 3; k++)
      @(posedge clk);
    if (k == 70000)
      stall;
    check({u_mmh_far_end.got[0], u_mmh_far_end.got[1], u_mmh_far_end.got[2]}, 24'hB10C55);
    // queue empty now; a key with local off must not reach the sound generator
    axw(`MMH_OFS_CTRL, 32'h00004101);
    axw(`MMH_OFS_EVENT, 32'h00203C00);
    repeat (2) @(posedge clk);
    check({r, nStb}, {`MMH_RESP_OKAY, 32'd3});
    axw(`MMH_OFS_TEMPO, 32'h00000064);
    nTick = 0;
    repeat (300) @(posedge clk);
    check(nTick >= 2 && nTick <= 3, 1'b1);
    axw(`MMH_OFS_CTRL, 32'h00001600);
    nTick = 0;
    repeat (300) @(posedge clk);
    for (k = 0; k < 3; k++)
      u_mmh_far_end.send(`MMH_TIMING_CLOCK);
    repeat (4) @(posedge clk);
    check(nTick, 3);
    axw(`MMH_OFS_CTRL, 32'h00001A00);
    repeat (400) @(posedge clk);
    nTick = 0;
    repeat (300) @(posedge clk);
    check(nTick >= 2 && nTick <= 3, 1'b1);
    wrap_up;
  end
endmodule : test_midi_message_handler
`default_nettype wire
